// ===== include/pblc_pkg.sv
package pblc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'h16;
  localparam logic [7:0] STAT_IDX = 8'h17;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hF0FF;

  localparam int CB_WRAP = 15;
  localparam int CB_RAND = 14;
  localparam int CB_SHORT = 13;
  localparam int CB_GEN = 12;
  localparam int CB_RFWD = 7;
  localparam int CB_LFWD = 6;
  localparam int CB_LOOP = 2;
  localparam int CB_PCS = 0;

  localparam int SB_LOCK = 11;
  localparam int SB_LOST = 10;
  localparam int SB_BUSY = 9;
  localparam int SB_SCRM = 8;
  localparam int SB_SCRS = 7;
  localparam int SB_AWAKE = 6;

  // ------------------------------------------------------------
  // encodings and counts
  // ------------------------------------------------------------
  localparam logic [3:0] LOOP_REV = 4'h8;
  localparam logic [3:0] LOOP_EXT = 4'h4;
  localparam logic [3:0] LOOP_ANA = 4'h2;
  localparam logic [3:0] LOOP_DIG = 4'h1;
  localparam logic [1:0] PCS_POST_MLT3 = 2'h3;
  localparam logic [1:0] PCS_POST_SCR = 2'h2;
  localparam logic [1:0] PCS_PRE_SCR = 2'h1;

  localparam logic [10:0] FRAME_LEN_SHORT = 11'd64;
  localparam logic [10:0] FRAME_LEN_LONG = 11'd1518;
  localparam logic [7:0] CONST_BYTE = 8'h55;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [3:0] LOCK_GOOD = 4'h8;
  localparam logic [1:0] PRIME_BYTES = 2'h2;
  localparam int CNT_WIDTH = 16;

  typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_HOLD} pblc_gen_state_t;

  // eight serial steps of x15 + x14 + 1, newest bit in the lsb
  function automatic logic [14:0] prbs_step8(input logic [14:0] s);
    logic [14:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[13:0], r[14] ^ r[13]};
    end
    return r;
  endfunction
endpackage

// ===== include/pblc_chk_if.sv
`timescale 1ns/10ps
interface pblc_chk_if;
  logic en;
  logic rx_valid;
  logic [7:0] rx_data;
  logic byte_stb;
  logic err_stb;
  logic locked;
  logic lost;
  modport chk (input en, rx_valid, rx_data, output byte_stb, err_stb, locked, lost);
  modport ctl (output en, rx_valid, rx_data, input byte_stb, err_stb, locked, lost);
endinterface

// ===== design/pblc_prbs_chk.sv
`timescale 1ns/10ps
module pblc_prbs_chk
  import pblc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // checker link
  pblc_chk_if.chk cif
);
  logic [14:0] hist_reg;
  logic [1:0] prime_reg;
  logic [3:0] good_reg;
  logic locked_reg;

  // the last two bytes rebuild the generator state, so a looped stream locks by itself
  wire logic [14:0] pred = prbs_step8(hist_reg);
  wire logic take = cif.en & cif.rx_valid;
  wire logic check = take & (prime_reg == PRIME_BYTES);
  wire logic miss = check & (cif.rx_data != pred[7:0]);
  wire logic hit = check & ~miss & (hist_reg != 15'h0000);

  always_ff @(posedge clk) begin
    if (!nrst || !cif.en) begin
      hist_reg <= 15'h0000;
      prime_reg <= 2'h0;
      good_reg <= 4'h0;
      locked_reg <= 1'b0;
    end else if (take) begin
      hist_reg <= {hist_reg[6:0], cif.rx_data};
      prime_reg <= (prime_reg == PRIME_BYTES) ? prime_reg : prime_reg + 2'h1;
      good_reg <= miss ? 4'h0 : (good_reg == LOCK_GOOD ? good_reg : good_reg + 4'h1);
      locked_reg <= ~miss & (locked_reg | (hit & good_reg == LOCK_GOOD - 4'h1));
    end
  end

  assign cif.locked = locked_reg;
  assign cif.lost = miss & locked_reg;
  assign cif.byte_stb = take;
  assign cif.err_stb = miss;

  chk_lock_drop: assert property (@(posedge clk) disable iff (!nrst)
    locked_reg && miss |=> !locked_reg)
    else $error("checker kept lock after a mismatched byte");
endmodule

// ===== design/pblc_wrap_cnt.sv
`timescale 1ns/10ps
module pblc_wrap_cnt
  import pblc_pkg::*;
#(
  parameter int W = CNT_WIDTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // count control
  input wire logic inc,
  input wire logic wrap_mode,
  output logic wrap_pulse
);
  logic [W-1:0] cnt_reg;
  logic pulse_reg;
  wire logic at_max = &cnt_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= inc & at_max & wrap_mode;
      // without wrap mode the count sticks at full scale
      if (inc && (!at_max || wrap_mode)) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign wrap_pulse = pulse_reg;

  chk_wrap_restart: assert property (@(posedge clk) disable iff (!nrst)
    inc && at_max && wrap_mode |=> wrap_pulse && cnt_reg == '0 ##1 !wrap_pulse)
    else $error("full counter did not pulse once and restart");
  chk_sat_hold: assert property (@(posedge clk) disable iff (!nrst)
    inc && at_max && !wrap_mode |=> !wrap_pulse && at_max)
    else $error("counter left full scale without wrap mode");
endmodule

// ===== design/pblc_top.sv
`timescale 1ns/10ps
module pblc_top
  import pblc_pkg::*;
#(
  parameter int CNT_W = CNT_WIDTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core state
  input wire logic speed_100,
  input wire logic speed_gbit,
  input wire logic scr_master_legacy,
  input wire logic scr_slave_legacy,
  input wire logic core_normal_power,
  // received byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // generated frame stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_sof,
  output logic tx_eof,
  input wire logic tx_ready,
  // loop point selection
  output logic loop_reverse,
  output logic loop_external,
  output logic loop_analog,
  output logic loop_digital,
  output logic rev_loop_to_mac,
  output logic mii_loop_to_line,
  // coding sublayer loops
  output logic pcs_loop_post_mlt3,
  output logic pcs_loop_post_scr,
  output logic pcs_loop_pre_scr,
  output logic pcs_loop_gbit,
  // prbs counter wrap pulses
  output logic byte_wrap_pulse,
  output logic err_wrap_pulse
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic lost_reg;
  logic lost_next;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [15:0] stat_word;
  pblc_gen_state_t gst_reg;
  pblc_gen_state_t gst_next;
  logic [10:0] bcnt_reg;
  logic [10:0] bcnt_next;
  logic [10:0] len_reg;
  logic [10:0] len_next;
  logic [14:0] prbs_reg;
  logic [14:0] prbs_next;
  logic tx_valid_reg;
  logic tv_next;
  logic [7:0] tx_data_reg;
  logic [7:0] td_next;
  logic tx_sof_reg;
  logic sof_next;
  logic tx_eof_reg;
  logic eof_next;
  logic [1:0] wrap_pulses;
  logic [1:0] wrap_incs;

  pblc_chk_if cif ();

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire logic sel_ctrl = paddr == CTRL_ADDR;
  wire logic sel_stat = paddr == STAT_ADDR;
  wire logic addr_hit = sel_ctrl | sel_stat;
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable;
  wire logic wr_ctrl = access & pwrite & sel_ctrl;
  wire logic rd_stat = access & ~pwrite & sel_stat;
  wire logic [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & CTRL_WMASK;

  wire logic wrap_mode = ctrl_reg[CB_WRAP];
  wire logic rand_sel = ctrl_reg[CB_RAND];
  wire logic short_sel = ctrl_reg[CB_SHORT];
  wire logic gen_en = ctrl_reg[CB_GEN];
  wire logic [3:0] loop_sel = ctrl_reg[CB_LOOP +: 4];
  wire logic [1:0] pcs_sel = ctrl_reg[CB_PCS +: 2];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  assign ctrl_next = wr_ctrl ? ((ctrl_reg & ~wmask) | (pwdata[15:0] & wmask)) : ctrl_reg;
  // a read clears only a drop that it actually returned; a new drop wins
  assign lost_next = cif.lost | (lost_reg & ~(rd_stat & prdata_reg[SB_LOST]));
  wire logic gen_busy = (gst_reg == GEN_SEND) | tx_valid_reg;

  always_comb begin
    stat_word = STAT_RST;
    stat_word[SB_LOCK] = cif.locked;
    stat_word[SB_LOST] = lost_reg;
    stat_word[SB_BUSY] = gen_busy;
    stat_word[SB_SCRM] = scr_master_legacy;
    stat_word[SB_SCRS] = scr_slave_legacy;
    stat_word[SB_AWAKE] = core_normal_power;
  end

  // read data is taken in the setup cycle so the access phase needs no wait
  wire logic [31:0] rd_word = sel_ctrl ? {16'h0000, ctrl_reg} :
                              sel_stat ? {16'h0000, stat_word} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
      lost_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      lost_reg <= lost_next;
      prdata_reg <= setup ? rd_word : prdata_reg;
      pslverr_reg <= setup ? ~addr_hit : pslverr_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg & access;

  // ------------------------------------------------------------
  // loop selection
  // ------------------------------------------------------------
  // a code with more than one bit set selects no loop
  assign loop_reverse = loop_sel == LOOP_REV;
  assign loop_external = loop_sel == LOOP_EXT;
  assign loop_analog = loop_sel == LOOP_ANA;
  assign loop_digital = loop_sel == LOOP_DIG;
  assign rev_loop_to_mac = loop_reverse & ctrl_reg[CB_RFWD];
  assign mii_loop_to_line = loop_digital & ctrl_reg[CB_LFWD];
  assign pcs_loop_post_mlt3 = speed_100 & (pcs_sel == PCS_POST_MLT3);
  assign pcs_loop_post_scr = speed_100 & (pcs_sel == PCS_POST_SCR);
  assign pcs_loop_pre_scr = speed_100 & (pcs_sel == PCS_PRE_SCR);
  assign pcs_loop_gbit = speed_gbit & pcs_sel[0];

  // ------------------------------------------------------------
  // frame generator
  // ------------------------------------------------------------
  wire logic [14:0] prbs_step = prbs_step8(prbs_reg);
  wire logic slot_free = ~tx_valid_reg | tx_ready;
  wire logic last_byte = bcnt_reg == len_reg - 11'd1;
  wire logic [10:0] pick_len = short_sel ? FRAME_LEN_SHORT : FRAME_LEN_LONG;
  wire logic emit = (gst_reg == GEN_SEND) & gen_en & slot_free;

  always_comb begin
    gst_next = gst_reg;
    bcnt_next = bcnt_reg;
    len_next = len_reg;
    prbs_next = rand_sel ? prbs_reg : PRBS_SEED;
    tv_next = tx_valid_reg & ~tx_ready & gen_en;
    td_next = tx_data_reg;
    sof_next = tx_sof_reg;
    eof_next = tx_eof_reg;
    unique case (gst_reg)
      GEN_IDLE: begin
        if (gen_en) begin
          gst_next = GEN_SEND;
          bcnt_next = 11'd0;
          len_next = pick_len;
        end
      end
      GEN_SEND: begin
        if (!gen_en) begin
          gst_next = GEN_IDLE;
        end else if (slot_free) begin
          tv_next = 1'b1;
          td_next = rand_sel ? prbs_step[7:0] : CONST_BYTE;
          sof_next = bcnt_reg == 11'd0;
          eof_next = last_byte;
          bcnt_next = bcnt_reg + 11'd1;
          if (rand_sel) begin
            prbs_next = prbs_step;
          end
          if (last_byte) begin
            bcnt_next = 11'd0;
            len_next = pick_len;
            // constant payload stops after one frame until the enable is cleared
            gst_next = rand_sel ? GEN_SEND : GEN_HOLD;
          end
        end
      end
      GEN_HOLD: begin
        if (!gen_en) begin
          gst_next = GEN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gst_reg <= GEN_IDLE;
      bcnt_reg <= 11'd0;
      len_reg <= FRAME_LEN_LONG;
      prbs_reg <= PRBS_SEED;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_sof_reg <= 1'b0;
      tx_eof_reg <= 1'b0;
    end else begin
      gst_reg <= gst_next;
      bcnt_reg <= bcnt_next;
      len_reg <= len_next;
      prbs_reg <= prbs_next;
      tx_valid_reg <= tv_next;
      tx_data_reg <= td_next;
      tx_sof_reg <= sof_next;
      tx_eof_reg <= eof_next;
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign tx_sof = tx_sof_reg;
  assign tx_eof = tx_eof_reg;

  // ------------------------------------------------------------
  // prbs checker and counters
  // ------------------------------------------------------------
  assign cif.en = rand_sel;
  assign cif.rx_valid = rx_valid;
  assign cif.rx_data = rx_data;

  pblc_prbs_chk u_chk (
    .clk(clk),
    .nrst(nrst),
    .cif(cif)
  );

  assign wrap_incs = {cif.err_stb, cif.byte_stb};

  // index 0 counts every byte the checker takes, priming bytes included, index 1 counts byte errors
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      pblc_wrap_cnt #(.W(CNT_W)) u_cnt (
        .clk(clk),
        .nrst(nrst),
        .inc(wrap_incs[gi]),
        .wrap_mode(wrap_mode),
        .wrap_pulse(wrap_pulses[gi])
      );
    end
  endgenerate

  assign byte_wrap_pulse = wrap_pulses[0];
  assign err_wrap_pulse = wrap_pulses[1];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic [10:0] acc_cnt;
  wire logic accept = tx_valid & tx_ready;

  always_ff @(posedge clk) begin
    if (!nrst || !gen_en) begin
      acc_cnt <= 11'd0;
    end else if (accept) begin
      acc_cnt <= tx_eof ? 11'd0 : acc_cnt + 11'd1;
    end
  end

  chk_resv_zero: assert property (
    access && !pwrite && sel_ctrl |-> prdata[11:8] == 4'h0)
    else $error("reserved control bits read nonzero");
  chk_loop_decode: assert property (
    loop_sel == LOOP_REV |-> loop_reverse && !loop_external && !loop_analog && !loop_digital)
    else $error("reverse loop code decoded wrongly");
  chk_rev_forward: assert property (
    rev_loop_to_mac == (loop_sel == LOOP_REV && ctrl_reg[CB_RFWD]))
    else $error("host forward outside reverse loop");
  chk_line_forward: assert property (
    mii_loop_to_line == (loop_sel == LOOP_DIG && ctrl_reg[CB_LFWD]))
    else $error("line forward outside mii loop");
  chk_pcs_fast: assert property (
    speed_100 && pcs_sel == 2'h2 |-> pcs_loop_post_scr && !pcs_loop_post_mlt3 && !pcs_loop_pre_scr)
    else $error("100 mbit coding loop point wrong");
  chk_pcs_gbit: assert property (
    speed_gbit && pcs_sel == 2'h3 |-> pcs_loop_gbit)
    else $error("gigabit coding loop missing");
  chk_gen_off: assert property (
    !gen_en |=> !tx_valid && gst_reg != GEN_SEND)
    else $error("generator ran while disabled");
  chk_const_data: assert property (
    emit && !rand_sel |=> tx_valid && tx_data == CONST_BYTE)
    else $error("constant payload byte wrong");
  chk_one_frame: assert property (
    gst_reg == GEN_HOLD |-> !(tx_valid && tx_sof))
    else $error("second constant frame started");
  chk_no_lock_const: assert property (
    !rand_sel |=> !cif.locked)
    else $error("checker active with constant payload");
  chk_back_to_back: assert property (
    accept && tx_eof && rand_sel && gen_en && gst_reg == GEN_SEND |=> tx_valid && tx_sof)
    else $error("prbs frames not back to back");
  chk_frame_len: assert property (
    accept && tx_eof |-> acc_cnt == FRAME_LEN_SHORT - 11'd1 || acc_cnt == FRAME_LEN_LONG - 11'd1)
    else $error("frame length is neither 64 nor 1518");
  chk_lost_latch: assert property (
    cif.lost |=> lost_reg ##1 lost_reg || $past(rd_stat))
    else $error("lock drop not latched");
  chk_lost_clear: assert property (
    rd_stat && prdata_reg[SB_LOST] && !cif.lost |=> !lost_reg)
    else $error("lock drop not cleared by read");
  chk_stat_read: assert property (
    setup && sel_stat |=> prdata[SB_LOCK] == $past(cif.locked) && prdata[SB_BUSY] == $past(gen_busy)
      && prdata[SB_SCRM] == $past(scr_master_legacy) && prdata[SB_SCRS] == $past(scr_slave_legacy)
      && prdata[SB_AWAKE] == $past(core_normal_power))
    else $error("status read does not match block state");
  chk_checker_on: assert property (
    rand_sel && !gen_en |-> cif.en)
    else $error("checker off with random payload");

  cov_prbs_frames: cover property (accept && tx_eof && rand_sel ##1 tx_valid && tx_sof);
  cov_single_frame: cover property (accept && tx_eof && !rand_sel ##1 gst_reg == GEN_HOLD);
  cov_lock_lost: cover property (cif.locked ##1 cif.lost);
  cov_lost_read: cover property (rd_stat && prdata_reg[SB_LOST]);
  cov_bad_addr: cover property (pslverr);
endmodule

// ===== bench/pblc_link_model.sv
`timescale 1ns/10ps
module pblc_link_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // test controls
  input wire logic stall,
  input wire logic corrupt,
  // frames from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // looped bytes back to the block
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic pend;

  // ----------------------------------------
  // line loopback
  // ----------------------------------------
  // idle data toggles every cycle so a stale byte never passes as a fresh one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      pend <= 1'b0;
    end else begin
      tx_ready <= !stall;
      rx_valid <= tx_valid && tx_ready;
      if (tx_valid && tx_ready) begin
        rx_data <= pend ? ~tx_data : tx_data;
        pend <= corrupt;
      end else begin
        rx_data <= ~rx_data;
        pend <= pend || corrupt;
      end
    end
  end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import pblc_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  wire logic [3:0] pcs;
  wire logic [5:0] loops;
  logic [7:0] rx_data, tx_data;
  logic speed_100, speed_gbit, m_leg, s_leg, awake, rx_valid, tx_valid, tx_sof, tx_eof, tx_ready;
  logic stall, corrupt, byte_wrap, err_wrap, prev_wrap, prbs_on, last_eof;
  logic [32:0] exp_e;
  logic [32:0] rd_q[$];
  int len_q[$];
  int n_errors, n_compared, seed, n_rise, n_high, n_err_wrap, flen, k;
  logic [3:0] lc[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h3};

  pblc_top #(.CNT_W(4)) dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_100(speed_100), .speed_gbit(speed_gbit), .scr_master_legacy(m_leg), .scr_slave_legacy(s_leg),
    .core_normal_power(awake), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_ready(tx_ready), .loop_reverse(loops[5]),
    .loop_external(loops[4]), .loop_analog(loops[3]), .loop_digital(loops[2]), .rev_loop_to_mac(loops[1]),
    .mii_loop_to_line(loops[0]), .pcs_loop_post_mlt3(pcs[3]), .pcs_loop_post_scr(pcs[2]),
    .pcs_loop_pre_scr(pcs[1]), .pcs_loop_gbit(pcs[0]), .byte_wrap_pulse(byte_wrap), .err_wrap_pulse(err_wrap));

  pblc_link_model link_u (.clk(clk), .nrst(nrst), .stall(stall), .corrupt(corrupt), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // the expected answer is noted before the transfer; the bus monitor compares it
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     input logic [32:0] e);
    rd_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hF, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, 4'hF, {1'b0, e});
  endtask

  function automatic logic [31:0] st(input logic lk, input logic ls, input logic bz);
    return {20'h0, lk, ls, bz, m_leg, s_leg, awake, 6'h0};
  endfunction

  // ----------------------------------------
  // clock, stalls, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    stall = 1'b0;
    @(posedge nrst);
    forever begin
      @(posedge clk);
      stall <= ($random(seed) % 4) == 0;
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      exp_e = rd_q.pop_front();
      check({31'h0, pslverr}, {31'h0, exp_e[32]});
      if (!pwrite) check(prdata, exp_e[31:0]);
    end
    prev_wrap <= byte_wrap;
    n_high += int'(byte_wrap);
    n_rise += int'(byte_wrap && !prev_wrap);
    n_err_wrap += int'(err_wrap);
    if (tx_valid && tx_ready) begin
      if (last_eof) check(tx_sof, 1'b1);
      if (!prbs_on) check(tx_data, CONST_BYTE);
      flen = tx_sof ? 1 : flen + 1;
      last_eof = tx_eof;
      if (tx_eof) check(32'(flen), 32'(len_q.size() > 0 ? len_q.pop_front() : 64));
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h2148FFA4;
    {n_errors, n_compared, n_rise, n_high, n_err_wrap, flen} = '0;
    {nrst, psel, penable, pwrite, speed_100, speed_gbit, corrupt, prbs_on, prev_wrap} = '0;
    {paddr, pwdata, pstrb} = '0;
    last_eof = 1'b1;
    {m_leg, s_leg, awake} = 3'($random(seed));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(CTRL_ADDR, 32'h0);
    rd(STAT_ADDR, st(0, 0, 0));
    wr(CTRL_ADDR, 32'h0F3C);
    rd(CTRL_ADDR, 32'h003C);
    apb(CTRL_ADDR, 1'b1, 32'hFF00, 4'h1, 33'h0);
    rd(CTRL_ADDR, 32'h0000);
    wr(STAT_ADDR, 32'hFFFF);
    apb(12'h060, 1'b0, 32'h0, 4'hF, {1'b1, 32'h0});
    rd(STAT_ADDR, st(0, 0, 0));
    for (int i = 0; i < 5; i++) begin
      wr(CTRL_ADDR, {24'h0, lc[i] == 4'h8, lc[i] == 4'h1, lc[i], 2'h0});
      check(loops, {$onehot(lc[i]) ? lc[i] : 4'h0, lc[i] == 4'h8, lc[i] == 4'h1});
    end
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        speed_100 <= (s == 0);
        speed_gbit <= (s == 1);
        wr(CTRL_ADDR, 32'(p));
        check(pcs, s ? {3'h0, p[0]} : {p == 3, p == 2, p == 1, 1'b0});
      end
    end
    wr(CTRL_ADDR, 32'h0);
    for (int i = 0; i < 2; i++) begin
      len_q.push_back(i ? 1518 : 64);
      wr(CTRL_ADDR, i ? 32'h1000 : 32'h3000);
      repeat (40) @(posedge clk);
      rd(STAT_ADDR, st(0, 0, 1));
      for (k = 0; k < 4000 && !(tx_valid && tx_ready && tx_eof); k++) @(posedge clk);
      repeat (50) @(posedge clk);
      check(tx_valid, 1'b0);
      rd(STAT_ADDR, st(0, 0, 0));
      wr(CTRL_ADDR, 32'h0);
    end
    prbs_on = 1'b1;
    wr(CTRL_ADDR, 32'h7000);
    repeat (300) @(posedge clk);
    check(n_rise, 0);
    wr(CTRL_ADDR, 32'hF000);
    repeat (300) @(posedge clk);
    rd(STAT_ADDR, st(1, 0, 1));
    check(n_rise > 0, 1'b1);
    check(n_high, n_rise);
    corrupt <= 1'b1;
    @(posedge clk);
    corrupt <= 1'b0;
    // the next accepted byte comes back inverted; stop the generator before a relock
    do @(posedge clk); while (!(tx_valid && tx_ready));
    wr(CTRL_ADDR, 32'hC000);
    repeat (10) @(posedge clk);
    check(tx_valid, 1'b0);
    rd(STAT_ADDR, st(0, 1, 0));
    rd(STAT_ADDR, st(0, 0, 0));
    check(n_err_wrap, 0);
    final_report();
  end
endmodule
